// ---- hdl/rsp_pkg.sv ----
// Package: constants and carrier types for the reset sequencer and prescaler
package rsp_pkg;

  // Timing counts in clk_sys cycles
  localparam int unsigned PIN_DRIVE_CYC   = 32;
  localparam int unsigned INTERNAL_RESET_TAIL_CYC   = 32;
  localparam int unsigned POR_WAIT_CYC    = 4096;
  localparam int unsigned CPU_REL_CYC     = 64;
  localparam int unsigned PIN_MIN_CYC     = 67;
  localparam int unsigned PIN_MIN_POR_CYC = 4163;
  localparam int unsigned SREC_SHORT_CYC  = 32;
  localparam int unsigned SREC_LONG_CYC   = 4096;

  // Prescaler layout
  localparam int unsigned PRESC_W      = 13;
  localparam int unsigned PRESC_SVC_LO = 4;
  localparam int unsigned PRESC_SVC_HI = 12;

  // Vector addresses and watchdog service address
  localparam logic [15:0] VEC_USER = 16'hfffe;
  localparam logic [15:0] VEC_MON  = 16'hfefe;
  localparam logic [15:0] WDOG_SVC_ADDR = 16'hffff;

  // Avalon register offsets (byte addresses)
  localparam logic [3:0] OFS_CAUSE = 4'h0;
  localparam logic [3:0] OFS_CTRL  = 4'h4;
  localparam logic [3:0] OFS_PRESC = 4'h8;

  // Cause register bit positions
  localparam int unsigned CB_POR  = 7;
  localparam int unsigned CB_PIN  = 6;
  localparam int unsigned CB_WDOG = 5;
  localparam int unsigned CB_OP   = 4;
  localparam int unsigned CB_AD   = 3;
  localparam int unsigned CB_MOD  = 2;
  localparam int unsigned CB_LVI  = 1;
  localparam logic [7:0] CAUSE_RST = 8'h80;

  // Control register bits
  localparam int unsigned CTL_STOPEN = 0;
  localparam int unsigned CTL_SHORT_STOP_RECOVERY  = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // Sequencer states
  typedef enum logic [2:0] {
    RSP_RUN, RSP_POR_WAIT, RSP_PIN_LOW, RSP_INTERNAL_RESET_TAIL, RSP_EXT_HOLD, RSP_STOP_REC
  } rsp_state_t;

  // CPU decode inputs carried together
  typedef struct packed {
    logic bad_opcode;
    logic stop_exec;
    logic opcode_fetch;
    logic unmapped;
    logic wake;
    logic monitor_mode;
    logic break_state;
  } rsp_cpu_t;

endpackage : rsp_pkg

// ---- hdl/rsp_top.sv ----
// Reset sequencer, reset cause flags and 13-bit prescaler
//
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Every reset cause asserts internal reset and selects user or monitor vector.
// - Internal resets clear the prescaler; the external pin reset leaves it alone.
// - Each reset cause sets its own flag in the cause register (cause_q).
// - Pin flag needs 67 low cycles, or 4163 after power-on or low supply.
// - Internal causes drive pin low 32 cycles, then hold internal reset 32 more.
// - Power-on and low supply first count 4096 cycles with the pin forced low.
// - After power-on clocks stay off 4096 cycles; CPU released 64 later.
// - Power-on sets its flag and clears all other flags.
// - Watchdog overflow resets and sets its flag; its input is synchronised.
// - Write to FFFF clears watchdog counter and prescaler bits 12 to 4.
// - Watchdog disabled only by high-voltage detects in monitor or break state.
// - Illegal instruction sets bad opcode flag and resets.
// - Stop with stop-enable clear is treated as an illegal opcode.
// - Only opcode fetches from unmapped addresses set the flag and reset.
// - Low supply sets its flag, holds pin 4128 cycles, releases CPU 32 later.
// - Monitor entry with blank vectors causes an internal reset driving the pin.
// - Prescaler is 13 bits, advances every cycle, overflow clocks the watchdog.
// - Stop clears the prescaler; wake recovery lasts 32 or 4096 cycles.
// - After reset states the prescaler runs freely.
// - An outside low on the reset pin halts all processing.
module rsp_top #(
  parameter int unsigned POR_WAIT  = rsp_pkg::POR_WAIT_CYC,
  parameter int unsigned SREC_LONG = rsp_pkg::SREC_LONG_CYC,
  parameter int unsigned PIN_MIN_POR = rsp_pkg::PIN_MIN_POR_CYC,
  parameter int unsigned WDOG_W    = 8
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // Reset sources
  input  wire logic             power_up_pulse,
  input  wire logic             low_supply_in,
  input  wire logic             debug_entry_reset,
  input  wire logic             watchdog_ovf_in,
  input  wire logic             hv_reset_pin,
  input  wire logic             hv_ext_irq_pin,
  input  wire rsp_pkg::rsp_cpu_t cpu_in,
  input  wire logic [15:0]      cpu_addr,
  input  wire logic             cpu_write,
  // Reset pin, open drain
  input  wire logic             reset_pin_n_i,
  output logic                  reset_pin_n_o,
  output logic                  reset_pin_n_oe,
  // Reset and clock outputs
  output logic                  internal_reset,
  output logic                  internal_bus_clocks,
  output logic                  cpu_run,
  output logic [15:0]           reset_vector,
  output logic                  watchdog_clk_en,
  output logic                  watchdog_enable,
  output logic [WDOG_W-1:0]     watchdog_count,
  // Avalon-MM slave
  input  wire logic [3:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  output logic [31:0]           avs_readdata,
  output logic                  avs_waitrequest
);

  initial begin
    if (POR_WAIT < 1 || SREC_LONG < 1 || WDOG_W < 1 || WDOG_W > 16 ||
        PIN_MIN_POR <= POR_WAIT) $error("rsp_top: bad parameter");
  end

  localparam int unsigned CW = 13;

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers: three flops, change accepted when stages two and three agree
  logic [2:0] pin_s_q, wd_s_q, lvi_s_q, por_s_q;
  logic       pin_low_q, wd_ev_q, lvi_q, por_q;

  always_ff @(posedge clk_sys) begin
    pin_s_q <= {pin_s_q[1:0], ~reset_pin_n_i};
    wd_s_q  <= {wd_s_q[1:0], watchdog_ovf_in};
    lvi_s_q <= {lvi_s_q[1:0], low_supply_in};
    por_s_q <= {por_s_q[1:0], power_up_pulse};
  end

  // Filtered levels; stage one feeds only stage two
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pin_low_q <= 1'b0;
      wd_ev_q   <= 1'b0;
      lvi_q     <= 1'b0;
      por_q     <= 1'b0;
    end else begin
      if (pin_s_q[1] == pin_s_q[2]) pin_low_q <= pin_s_q[2];
      if (wd_s_q[1] == wd_s_q[2])   wd_ev_q   <= wd_s_q[2];
      if (lvi_s_q[1] == lvi_s_q[2]) lvi_q     <= lvi_s_q[2];
      if (por_s_q[1] == por_s_q[2]) por_q     <= por_s_q[2];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Cause decode
  logic ctrl_stopen_q;
  logic ctrl_short_stop_recovery_q;
  logic wd_prev_q, lvi_prev_q, por_prev_q;
  rsp_pkg::rsp_state_t state_q, state_d;

  wire running      = (state_q == rsp_pkg::RSP_RUN);
  wire wd_disable   = (cpu_in.monitor_mode & (hv_reset_pin | hv_ext_irq_pin)) |
                      (cpu_in.break_state & hv_reset_pin);
  wire ev_por       = por_q & ~por_prev_q;
  wire ev_lvi       = lvi_q & ~lvi_prev_q;
  wire ev_wdog      = wd_ev_q & ~wd_prev_q & ~wd_disable;
  wire ev_op        = running & (cpu_in.bad_opcode |
                      (cpu_in.stop_exec & ~ctrl_stopen_q));
  wire ev_ad        = running & cpu_in.opcode_fetch & cpu_in.unmapped;
  wire ev_mod       = running & debug_entry_reset;
  wire ev_long      = ev_por | ev_lvi;
  wire ev_int       = ev_long | ev_wdog | ev_op | ev_ad | ev_mod;
  wire stop_enter   = running & cpu_in.stop_exec & ctrl_stopen_q;
  wire svc_write    = running & cpu_write & (cpu_addr == rsp_pkg::WDOG_SVC_ADDR);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wd_prev_q  <= 1'b0;
      lvi_prev_q <= 1'b0;
      por_prev_q <= 1'b0;
    end else begin
      wd_prev_q  <= wd_ev_q;
      lvi_prev_q <= lvi_q;
      por_prev_q <= por_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer; one counter times every phase
  logic [15:0] seq_cnt_q, seq_cnt_d;
  logic        long_src_q;
  logic [15:0] pin_cnt_q;

  // Internal causes win over an outside pin hold
  always_comb begin
    state_d   = state_q;
    seq_cnt_d = seq_cnt_q + 16'h0001;
    if (ev_int) begin
      state_d   = ev_long ? rsp_pkg::RSP_POR_WAIT : rsp_pkg::RSP_PIN_LOW;
      seq_cnt_d = 16'h0000;
    end else begin
      case (state_q)
        rsp_pkg::RSP_POR_WAIT: begin
          if (seq_cnt_q == 16'(POR_WAIT - 1)) begin
            state_d   = rsp_pkg::RSP_PIN_LOW;
            seq_cnt_d = 16'h0000;
          end
        end
        rsp_pkg::RSP_PIN_LOW: begin
          if (seq_cnt_q == 16'(rsp_pkg::PIN_DRIVE_CYC - 1)) begin
            state_d   = rsp_pkg::RSP_INTERNAL_RESET_TAIL;
            seq_cnt_d = 16'h0000;
          end
        end
        rsp_pkg::RSP_INTERNAL_RESET_TAIL: begin
          if (seq_cnt_q == 16'(rsp_pkg::INTERNAL_RESET_TAIL_CYC - 1)) begin
            state_d   = pin_low_q ? rsp_pkg::RSP_EXT_HOLD : rsp_pkg::RSP_RUN;
            seq_cnt_d = 16'h0000;
          end
        end
        rsp_pkg::RSP_EXT_HOLD: begin
          if (!pin_low_q) begin
            state_d   = rsp_pkg::RSP_PIN_LOW;
            seq_cnt_d = 16'h0000;
          end
        end
        rsp_pkg::RSP_STOP_REC: begin
          if (!cpu_in.wake && seq_cnt_q == 16'h0000) seq_cnt_d = 16'h0000;
          else if (seq_cnt_q == 16'((ctrl_short_stop_recovery_q ? rsp_pkg::SREC_SHORT_CYC
                                     : SREC_LONG) - 1)) begin
            state_d   = rsp_pkg::RSP_RUN;
            seq_cnt_d = 16'h0000;
          end
        end
        default: begin
          seq_cnt_d = 16'h0000;
          if (pin_low_q) state_d = rsp_pkg::RSP_EXT_HOLD;
          else if (stop_enter) state_d = rsp_pkg::RSP_STOP_REC;
        end
      endcase
    end
  end

  // Stop recovery counter parks at zero until wake
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_q   <= rsp_pkg::RSP_POR_WAIT;
      seq_cnt_q <= 16'h0000;
    end else begin
      state_q   <= state_d;
      seq_cnt_q <= seq_cnt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Cause flags; latest cause is recorded, power-on clears the rest
  logic [7:0] cause_q;
  wire  [15:0] pin_need = long_src_q ? 16'(PIN_MIN_POR) : 16'(rsp_pkg::PIN_MIN_CYC);
  wire  pin_flag = pin_low_q & (pin_cnt_q == pin_need - 16'h0001);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cause_q    <= rsp_pkg::CAUSE_RST;
      long_src_q <= 1'b1;
      pin_cnt_q  <= 16'h0000;
    end else begin
      pin_cnt_q <= pin_low_q ? ((pin_cnt_q == 16'hffff) ? pin_cnt_q
                               : pin_cnt_q + 16'h0001) : 16'h0000;
      if (ev_long) long_src_q <= 1'b1;
      else if (running) long_src_q <= 1'b0;
      if (ev_por) begin
        cause_q <= rsp_pkg::CAUSE_RST;
      end else begin
        if (ev_int) cause_q <= 8'h00;
        if (ev_lvi)  cause_q[rsp_pkg::CB_LVI]  <= 1'b1;
        if (ev_wdog) cause_q[rsp_pkg::CB_WDOG] <= 1'b1;
        if (ev_op)   cause_q[rsp_pkg::CB_OP]   <= 1'b1;
        if (ev_ad)   cause_q[rsp_pkg::CB_AD]   <= 1'b1;
        if (ev_mod)  cause_q[rsp_pkg::CB_MOD]  <= 1'b1;
        if (pin_flag) cause_q <= 8'h01 << rsp_pkg::CB_PIN;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Prescaler and watchdog counter
  logic [CW-1:0]     presc_q;
  logic [WDOG_W-1:0] wdog_q;
  wire  presc_ovf = (presc_q == {CW{1'b1}});
  wire  clr_presc = ev_int | stop_enter;
  wire  [CW-1:0] svc_mask = {{(CW-rsp_pkg::PRESC_SVC_HI-1){1'b0}},
                             {(rsp_pkg::PRESC_SVC_HI-rsp_pkg::PRESC_SVC_LO+1){1'b1}},
                             {rsp_pkg::PRESC_SVC_LO{1'b0}}};

  // External pin reset leaves the prescaler counting
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      presc_q <= '0;
      wdog_q  <= '0;
    end else begin
      if (clr_presc) presc_q <= '0;
      else if (svc_write) presc_q <= (presc_q + 13'h0001) & ~svc_mask;
      else presc_q <= presc_q + 13'h0001;
      if (svc_write || !running || wd_disable) wdog_q <= '0;
      else if (presc_ovf) wdog_q <= WDOG_W'(wdog_q + 1'b1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs; pin only pulled low, pull-up gives high
  wire drive_pin = (state_q == rsp_pkg::RSP_POR_WAIT) | (state_q == rsp_pkg::RSP_PIN_LOW);
  assign reset_pin_n_o       = 1'b0;
  assign reset_pin_n_oe      = drive_pin;
  assign internal_reset      = ~running & (state_q != rsp_pkg::RSP_STOP_REC);
  assign internal_bus_clocks = (state_q != rsp_pkg::RSP_POR_WAIT) &
                               (state_q != rsp_pkg::RSP_STOP_REC);
  assign cpu_run             = running;
  assign reset_vector        = cpu_in.monitor_mode ? rsp_pkg::VEC_MON : rsp_pkg::VEC_USER;
  assign watchdog_clk_en     = presc_ovf;
  assign watchdog_enable     = ~wd_disable;
  assign watchdog_count      = wdog_q;

  //////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle per access, then answer
  logic ack_q;
  logic [31:0] rdata_q;
  wire  req     = avs_read | avs_write;
  wire  hit_ctl = (avs_address == rsp_pkg::OFS_CTRL);
  wire  [31:0] rd_mux = (avs_address == rsp_pkg::OFS_CAUSE) ? {24'h0, cause_q} :
                        hit_ctl ? {30'h0, ctrl_short_stop_recovery_q, ctrl_stopen_q} :
                        (avs_address == rsp_pkg::OFS_PRESC) ? {19'h0, presc_q} :
                        32'h0000_0000;
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata    = rdata_q;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ack_q         <= 1'b0;
      rdata_q       <= 32'h0000_0000;
      ctrl_stopen_q <= rsp_pkg::CTRL_RST[rsp_pkg::CTL_STOPEN];
      ctrl_short_stop_recovery_q  <= rsp_pkg::CTRL_RST[rsp_pkg::CTL_SHORT_STOP_RECOVERY];
    end else begin
      ack_q <= req & ~ack_q;
      if (req && !ack_q) rdata_q <= rd_mux;
      // Write lands only at the edge where waitrequest is low
      if (internal_reset) begin
        ctrl_stopen_q <= rsp_pkg::CTRL_RST[rsp_pkg::CTL_STOPEN];
        ctrl_short_stop_recovery_q  <= rsp_pkg::CTRL_RST[rsp_pkg::CTL_SHORT_STOP_RECOVERY];
      end else if (avs_write && ack_q && hit_ctl) begin
        ctrl_stopen_q <= avs_writedata[rsp_pkg::CTL_STOPEN];
        ctrl_short_stop_recovery_q  <= avs_writedata[rsp_pkg::CTL_SHORT_STOP_RECOVERY];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  pin_low_span_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ($rose(state_q == rsp_pkg::RSP_PIN_LOW) && !ev_int) |->
      reset_pin_n_oe [*8]) else $error("pin released early");
  tail_reset_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q == rsp_pkg::RSP_INTERNAL_RESET_TAIL) |-> internal_reset && !reset_pin_n_oe)
    else $error("tail phase wrong");
  int_cause_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ev_int |=> internal_reset && reset_pin_n_oe) else $error("cause not reset");
  por_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ev_por |=> cause_q == rsp_pkg::CAUSE_RST) else $error("por flags wrong");
  op_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (ev_op && !ev_por && !pin_flag) |=> cause_q[rsp_pkg::CB_OP])
    else $error("opcode flag missing");
  presc_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    clr_presc |=> presc_q == '0) else $error("prescaler not cleared");
  svc_bits_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (svc_write && !clr_presc) |=> (presc_q & svc_mask) == '0)
    else $error("service clear wrong");
  clocks_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q == rsp_pkg::RSP_POR_WAIT) |-> !internal_bus_clocks && reset_pin_n_oe)
    else $error("clocks on during wait");
  pin_halt_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (pin_low_q && running) |=> !cpu_run) else $error("no halt on pin");
  pin_only_low_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    reset_pin_n_oe |-> !reset_pin_n_o) else $error("pin driven high");
  wdog_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (ev_wdog && !ev_por && !pin_flag) |=> cause_q[rsp_pkg::CB_WDOG])
    else $error("watchdog flag missing");
  ad_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (ev_ad && !ev_por && !pin_flag) |=> cause_q[rsp_pkg::CB_AD])
    else $error("address flag missing");
  mod_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (ev_mod && !ev_por && !pin_flag) |=> cause_q[rsp_pkg::CB_MOD] && reset_pin_n_oe)
    else $error("monitor entry reset wrong");
  lvi_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (ev_lvi && !ev_por && !pin_flag) |=> cause_q[rsp_pkg::CB_LVI] && !internal_bus_clocks)
    else $error("low supply reset wrong");
  stop_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (stop_enter && !ev_int) |=> presc_q == '0 && !internal_bus_clocks)
    else $error("stop entry wrong");

endmodule : rsp_top

`default_nettype wire

// ---- tb/rsp_pin_model.sv ----
// Reset pin partner: pull-up, device pull-down and an outside pull-down
`timescale 1ns/1ps
`default_nettype none
module rsp_pin_model (
  // Device side of the open-drain pin
  input  wire logic dev_o,
  input  wire logic dev_oe,
  // Outside reset source, asynchronous to the clock
  input  wire logic ext_pull,
  // Resolved pin level
  output logic      pin_n
);
  // Pull-up gives the high level; any pull-down wins at once
  assign pin_n = (ext_pull || (dev_oe && !dev_o)) ? 1'b0 : 1'b1;
endmodule : rsp_pin_model
`default_nettype wire

// ---- tb/rsp_top_tb_top.sv ----
// Self-checking bench for the reset sequencer and prescaler
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module rsp_top_tb_top;
  // Shortened long counts
  localparam int unsigned POR_W  = 16;
  localparam int unsigned SREC_L = 16;
  localparam int CBT [7] = '{rsp_pkg::CB_OP, rsp_pkg::CB_OP, rsp_pkg::CB_AD, rsp_pkg::CB_MOD,
                             rsp_pkg::CB_WDOG, rsp_pkg::CB_LVI, rsp_pkg::CB_POR};
  // Stimulus
  logic              clk_sys = 1'b0;
  logic              resetn = 1'b0;
  logic              power_up_pulse = 1'b0;
  logic              low_supply_in = 1'b0;
  logic              debug_entry_reset = 1'b0;
  logic              watchdog_ovf_in = 1'b0;
  logic              hv_reset_pin = 1'b0;
  logic              hv_ext_irq_pin = 1'b0;
  rsp_pkg::rsp_cpu_t cpu_in = '0;
  logic [15:0]       cpu_addr = 16'h0000;
  logic              cpu_write = 1'b0;
  logic              ext_pull = 1'b0;
  logic [3:0]        avs_address = 4'h0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = 32'h0;
  // Observed
  logic              pin_n, reset_pin_n_o, reset_pin_n_oe, internal_reset;
  logic              internal_bus_clocks, cpu_run, watchdog_clk_en, watchdog_enable;
  logic [15:0]       reset_vector;
  logic [7:0]        watchdog_count;
  logic [31:0]       avs_readdata, rd, p1;
  logic              avs_waitrequest;
  int                err_total = 0, comparisons = 0, cyc = 0, tk, c1, n, nb;
  int                rec [2];

  // Clock and cycle count
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  rsp_pin_model pin (.dev_o(reset_pin_n_o), .dev_oe(reset_pin_n_oe), .ext_pull(ext_pull),
                     .pin_n(pin_n));
  rsp_top #(.POR_WAIT(POR_W), .SREC_LONG(SREC_L), .PIN_MIN_POR(83)) dut (
    .clk_sys(clk_sys), .resetn(resetn), .power_up_pulse(power_up_pulse),
    .low_supply_in(low_supply_in), .debug_entry_reset(debug_entry_reset),
    .watchdog_ovf_in(watchdog_ovf_in), .hv_reset_pin(hv_reset_pin),
    .hv_ext_irq_pin(hv_ext_irq_pin), .cpu_in(cpu_in), .cpu_addr(cpu_addr),
    .cpu_write(cpu_write), .reset_pin_n_i(pin_n), .reset_pin_n_o(reset_pin_n_o),
    .reset_pin_n_oe(reset_pin_n_oe), .internal_reset(internal_reset),
    .internal_bus_clocks(internal_bus_clocks), .cpu_run(cpu_run),
    .reset_vector(reset_vector), .watchdog_clk_en(watchdog_clk_en),
    .watchdog_enable(watchdog_enable), .watchdog_count(watchdog_count),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, the only exit
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // A used-up wait bound is a mismatch and ends the run
  task automatic lim(input int cnt, input int mx);
    if (cnt >= mx) begin
      err_total++;
      $display("CHECK FAILED wait bound expected %0d seen %0d", mx, cnt);
      end_sim();
    end
  endtask : lim

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask : done

  // One Avalon access; request held until waitrequest is sampled low
  task automatic av_acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    tk = cyc;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
    lim(k, 50);
  endtask : av_acc

  task automatic rchk(input logic [3:0] a, input logic [31:0] e, input string nm);
    av_acc(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask : rchk

  task automatic till_run;
    n = 0;
    while (cpu_run !== 1'b1 && n < 400) begin
      n++;
      @(posedge clk_sys);
    end
    lim(n, 400);
  endtask : till_run

  // Raise one reset cause; synchronous ones last a single cycle
  task automatic fire(input int k);
    case (k)
      0: cpu_in.bad_opcode <= 1'b1;
      1: cpu_in.stop_exec <= 1'b1;
      2: cpu_in <= 7'b0011000;
      3: debug_entry_reset <= 1'b1;
      4: watchdog_ovf_in <= 1'b1;
      5: low_supply_in <= 1'b1;
      default: power_up_pulse <= 1'b1;
    endcase
    @(posedge clk_sys);
    cpu_in <= '0;
    debug_entry_reset <= 1'b0;
  endtask : fire

  // Pin-low span then internal-reset tail, counted from the pin going low
  task automatic run_seq(input int exp_lo);
    n = 0;
    while (reset_pin_n_oe !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk_sys);
    end
    lim(n, 20);
    {watchdog_ovf_in, low_supply_in, power_up_pulse} <= 3'b000;
    `CHK("pin driven level", 1'b0, reset_pin_n_o)
    n = 0;
    while (reset_pin_n_oe === 1'b1 && n < 9000) begin
      n++;
      @(posedge clk_sys);
    end
    `CHK("pin low cycles", exp_lo, n)
    n = 0;
    while (internal_reset === 1'b1 && n < 9000) begin
      n++;
      @(posedge clk_sys);
    end
    `CHK("reset tail cycles", 32, n)
    `CHK("cpu released", 1'b1, cpu_run)
  endtask : run_seq

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    `CHK("pin held in wait", 1'b1, reset_pin_n_oe)
    `CHK("bus clocks off", 1'b0, internal_bus_clocks)
    till_run();
    rchk(rsp_pkg::OFS_CAUSE, 32'h80, "cause after power on");
    rchk(rsp_pkg::OFS_CTRL, 32'h0, "ctrl default");
    rchk(4'hc, 32'h0, "unmapped read");
    av_acc(1'b1, rsp_pkg::OFS_CAUSE, 32'hff);
    rchk(rsp_pkg::OFS_CAUSE, 32'h80, "cause read only");
    av_acc(1'b1, rsp_pkg::OFS_CTRL, 32'h3);
    rchk(rsp_pkg::OFS_CTRL, 32'h3, "ctrl readback");
    done("registers");
    // All combinations of mode and high-voltage detects
    for (int i = 0; i < 16; i++) begin
      {hv_ext_irq_pin, hv_reset_pin, cpu_in.break_state, cpu_in.monitor_mode} <= 4'(i);
      @(posedge clk_sys);
      `CHK("vector", i[0] ? rsp_pkg::VEC_MON : rsp_pkg::VEC_USER, reset_vector)
      `CHK("wdog enable", !((i[0] && (i[2] || i[3])) || (i[1] && i[2])), watchdog_enable)
    end
    {hv_ext_irq_pin, hv_reset_pin} <= 2'b00;
    cpu_in <= '0;
    @(posedge clk_sys);
    done("vectors");
    // Every internal reset cause in turn; ctrl still holds 3 before the first
    for (int k = 0; k < 7; k++) begin
      fire(k);
      run_seq(k > 4 ? POR_W + 32 : 32);
      rchk(rsp_pkg::OFS_CAUSE, 32'h1 << CBT[k], "cause flag");
      if (k == 0) begin
        rchk(rsp_pkg::OFS_CTRL, 32'h0, "ctrl back to default");
        av_acc(1'b0, rsp_pkg::OFS_PRESC, 32'h0);
        `CHK("prescaler cleared", 1'b1, rd < 32'h60)
      end
    end
    done("causes");
    // Data access to an unmapped place must not reset
    cpu_in.unmapped <= 1'b1;
    @(posedge clk_sys);
    cpu_in <= '0;
    repeat (8) @(posedge clk_sys);
    `CHK("data access no reset", 1'b0, internal_reset)
    // Watchdog service write
    repeat (300) @(posedge clk_sys);
    cpu_addr <= rsp_pkg::WDOG_SVC_ADDR;
    cpu_write <= 1'b1;
    @(posedge clk_sys);
    cpu_write <= 1'b0;
    @(posedge clk_sys);
    `CHK("wdog count cleared", 8'h00, watchdog_count)
    av_acc(1'b0, rsp_pkg::OFS_PRESC, 32'h0);
    `CHK("service clears prescaler", 1'b1, rd < 32'h20)
    // Overflow period of the 13-bit prescaler
    n = 0;
    while (watchdog_clk_en !== 1'b1 && n < 9000) begin
      n++;
      @(posedge clk_sys);
    end
    lim(n, 9000);
    @(posedge clk_sys);
    n = 1;
    while (watchdog_clk_en !== 1'b1 && n < 9000) begin
      n++;
      @(posedge clk_sys);
    end
    `CHK("overflow period", 8192, n)
    done("prescaler");
    // Stop recovery, short then long, identical stimulus
    for (int m = 0; m < 2; m++) begin
      av_acc(1'b1, rsp_pkg::OFS_CTRL, m ? 32'h1 : 32'h3);
      cpu_in.stop_exec <= 1'b1;
      @(posedge clk_sys);
      cpu_in.stop_exec <= 1'b0;
      repeat (6) @(posedge clk_sys);
      cpu_in.wake <= 1'b1;
      @(posedge clk_sys);
      cpu_in.wake <= 1'b0;
      nb = 0;
      while (internal_bus_clocks !== 1'b1 && nb < 200) begin
        nb++;
        @(posedge clk_sys);
      end
      lim(nb, 200);
      rec[m] = nb;
      av_acc(1'b0, rsp_pkg::OFS_PRESC, 32'h0);
      `CHK("stop clears prescaler", 1'b1, rd < 32'h60)
    end
    `CHK("recovery difference", 32 - SREC_L, rec[0] - rec[1])
    done("stop");
    // Outside pull-down, too short then long enough
    av_acc(1'b0, rsp_pkg::OFS_PRESC, 32'h0);
    p1 = rd;
    c1 = tk;
    for (int s = 0; s < 2; s++) begin
      ext_pull <= 1'b1;
      repeat (s ? 70 : 40) @(posedge clk_sys);
      `CHK("halted by pin", 1'b0, cpu_run)
      ext_pull <= 1'b0;
      till_run();
      rchk(rsp_pkg::OFS_CAUSE, s ? 32'h40 : 32'h80, "pin flag");
    end
    av_acc(1'b0, rsp_pkg::OFS_PRESC, 32'h0);
    `CHK("prescaler kept", (tk - c1) & 32'h1fff, (rd - p1) & 32'h1fff)
    done("pin");
    end_sim();
  end
endmodule : rsp_top_tb_top
`default_nettype wire
